// >>> hdl/period_match_timer8_params.svh
`ifndef PERIOD_MATCH_TIMER8_PARAMS_SVH
`define PERIOD_MATCH_TIMER8_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL     12'h000
`define OFS_COUNT       12'h004
`define OFS_PERIOD      12'h008
`define OFS_INT_FLAGS   12'h00C
`define OFS_INT_CLEAR   12'h010
`define OFS_INT_ENABLE  12'h014

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTL_PRE_LSB     0
`define CTL_ON_BIT      2
`define CTL_POST_LSB    3
`define MATCH_FLAG_BIT  1
`define RST_COUNT       8'h00
`define RST_PERIOD      8'hFF
`define RST_CONTROL     7'h00

// ----------------------------------------
// timing: instruction clock is one quarter of the bus clock
// ----------------------------------------
`define INSTR_DIV       4
`endif

// >>> hdl/period_match_timer8_pkg.sv
package period_match_timer8_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] pre_sel_t;
  typedef logic [3:0] post_sel_t;
endpackage

// >>> hdl/period_match_timer8.sv
// Function
// - the count input is derived from an instruction clock running at one quarter of the oscillator rate.
// - the instruction clock passes a 1, 4 or 16 prescaler whose every output pulse adds one to the count.
// - the count and period registers are each eight bits wide.
// - the count is compared continuously with the period and runs upward from zero until they are equal.
// - after a match the count returns to zero on the next increment instead of passing the period.
// - each match advances a postscaler whose ratio is selectable from 1 to 16.
// - the postscaler output sets the match interrupt flag at bit 1 of the interrupt flag register.
// - software reads and writes both the count and the period registers in full at any time.
// - every reset loads the count with zero and the period with all ones.
// - writing one to the timer-on bit starts counting and writing zero stops it.
// - prescale and postscale ratios come from their select fields in the control register.
// - prescaler and postscaler counts clear on a count write, a control write and any reset.
// - a control write leaves the count value unchanged.
`include "period_match_timer8_params.svh"
`timescale 1ns/1ps
`default_nettype none

module period_match_timer8 (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  output logic                                  irq,
  output logic                                  match_out,
  output period_match_timer8_pkg::byte_t        count_out
);
  import period_match_timer8_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]  instr_div;
    logic [3:0]  pre_cnt;
    logic [3:0]  post_cnt;
    byte_t       count;
    byte_t       period;
    pre_sel_t    pre_sel;
    logic        on;
    post_sel_t   post_sel;
    logic        flag;
    logic        int_en;
    logic        match;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [3:0] pre_limit(input pre_sel_t sel);
    case (sel)
      2'h0:    pre_limit = 4'h0;
      2'h1:    pre_limit = 4'h3;
      default: pre_limit = 4'hF;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  logic access;
  logic wr;
  logic wr_ctl;
  logic wr_cnt;
  logic instr_tick;
  logic pre_tick;
  logic at_match;
  logic post_tick;

  assign access = psel && penable && !s_q.ready;
  assign wr     = access && pwrite;
  assign wr_ctl = wr && addr_hit(paddr, `OFS_CONTROL);
  assign wr_cnt = wr && addr_hit(paddr, `OFS_COUNT);

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  assign instr_tick = s_q.on && (s_q.instr_div == 2'(`INSTR_DIV - 1));
  assign pre_tick   = instr_tick && (s_q.pre_cnt == pre_limit(s_q.pre_sel));
  assign at_match   = (s_q.count == s_q.period);
  assign post_tick  = pre_tick && at_match && (s_q.post_cnt == s_q.post_sel);

  always_comb begin
    s_d = s_q;
    s_d.ready  = 1'b0;
    s_d.slverr = 1'b0;
    s_d.match  = 1'b0;
    if (s_q.on) begin
      s_d.instr_div = s_q.instr_div + 2'h1;
    end
    if (instr_tick) begin
      s_d.pre_cnt = pre_tick ? 4'h0 : s_q.pre_cnt + 4'h1;
    end
    if (pre_tick) begin
      if (at_match) begin
        s_d.count    = `RST_COUNT;
        s_d.match    = 1'b1;
        s_d.post_cnt = post_tick ? 4'h0 : s_q.post_cnt + 4'h1;
      end else begin
        s_d.count = s_q.count + 8'h01;
      end
    end
    if (post_tick) begin
      s_d.flag = 1'b1;
    end
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    if (access) begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          `OFS_CONTROL: begin
            s_d.pre_sel  = pwdata[`CTL_PRE_LSB +: 2];
            s_d.on       = pwdata[`CTL_ON_BIT];
            s_d.post_sel = pwdata[`CTL_POST_LSB +: 4];
          end
          `OFS_COUNT:      s_d.count  = pwdata[7:0];
          `OFS_PERIOD:     s_d.period = pwdata[7:0];
          `OFS_INT_CLEAR: begin
            if (pwdata[`MATCH_FLAG_BIT] && !post_tick) begin
              s_d.flag = 1'b0;
            end
          end
          `OFS_INT_ENABLE: s_d.int_en = pwdata[`MATCH_FLAG_BIT];
          `OFS_INT_FLAGS:  s_d.slverr = 1'b1;
          default:         s_d.slverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          `OFS_CONTROL:    s_d.rdata = {25'h0, s_q.post_sel, s_q.on, s_q.pre_sel};
          `OFS_COUNT:      s_d.rdata = {24'h0, s_q.count};
          `OFS_PERIOD:     s_d.rdata = {24'h0, s_q.period};
          `OFS_INT_FLAGS:  s_d.rdata = {30'h0, s_q.flag, 1'b0};
          `OFS_INT_ENABLE: s_d.rdata = {30'h0, s_q.int_en, 1'b0};
          `OFS_INT_CLEAR:  s_d.rdata = 32'h0000_0000;
          default:         s_d.slverr = 1'b1;
        endcase
      end
    end
    // a write to count or control restarts both scalers; control keeps count
    if (wr_cnt || wr_ctl) begin
      s_d.pre_cnt   = 4'h0;
      s_d.post_cnt  = 4'h0;
      s_d.instr_div = 2'h0;
    end
    s_d.irq = s_d.flag && s_d.int_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.count     <= `RST_COUNT;
      s_q.period    <= `RST_PERIOD;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata    = s_q.rdata;
  assign pready    = s_q.ready;
  assign pslverr   = s_q.slverr;
  assign irq       = s_q.irq;
  assign match_out = s_q.match;
  assign count_out = s_q.count;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reset_values: assert property (@(posedge pclk) $rose(presetn) |-> s_q.count == 8'h00 && s_q.period == 8'hFF)
    else $error("reset values wrong");
  a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn) pre_tick && at_match && !wr |=> s_q.count == 8'h00)
    else $error("count did not wrap");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      pre_tick && !at_match && !wr |=> s_q.count == $past(s_q.count) + 8'h01)
    else $error("count did not step");
  a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.on && !wr |=> $stable(s_q.count) && !s_q.match)
    else $error("count moved while off");
  a_ctl_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctl && !pre_tick |=> s_q.count == $past(s_q.count) && s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0)
    else $error("control write disturbed count");
  a_cnt_clears: assert property (@(posedge pclk) disable iff (!presetn) wr_cnt |=> s_q.pre_cnt == 4'h0)
    else $error("count write did not clear scaler");
  a_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
      instr_tick && !wr |=> !instr_tick [*3])
    else $error("instruction tick too fast");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) post_tick |=> s_q.flag ##1 s_q.irq == s_q.int_en)
    else $error("flag not set");
  a_pre16: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.pre_sel[1] && pre_tick && !wr |=> !pre_tick [*8])
    else $error("prescale 16 too fast");
  // a match pulse never lasts two cycles, even with period zero and prescale one
  a_match_single: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.match |=> !s_q.match)
    else $error("match pulse too long");
  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.flag && s_q.int_en && !wr |=> s_q.irq)
    else $error("interrupt not raised");
  c_match:   cover property (@(posedge pclk) s_q.match);
  c_flag:    cover property (@(posedge pclk) post_tick && s_q.post_sel == 4'hF);
  c_irq:     cover property (@(posedge pclk) $rose(irq));
  c_wr_ctl:  cover property (@(posedge pclk) wr_ctl && s_q.on);
endmodule

`default_nettype wire

// >>> bench/tb_period_match_timer8.sv
`include "period_match_timer8_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_period_match_timer8;
  import period_match_timer8_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        er, pready, pslverr, irq, match_out;
  byte_t       count_out;
  int          errors = 0, compares = 0, per, c, m, ps;
  int          mt[$];
  int          ps_list[3] = '{0, 3, 15};
  always #12.5 pclk = ~pclk;
  period_match_timer8 i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .match_out(match_out), .count_out(count_out));
  // model side: time of every match pulse
  always @(posedge pclk) if (match_out === 1'b1) mt.push_back($time);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // waits for matches; count may never pass the period meanwhile
  task automatic wait_n(input int want, input logic for_irq);
    for (int k = 0; k < 4000 && mt.size() < want && !(for_irq && irq === 1'b1); k++) begin
      @(posedge pclk);
      if (count_out > per) chk(count_out, per);
    end
    // let the match monitor record the pulse of this same edge
    #1;
  endtask
  initial begin
    #2000000;
    errors++;
    end_of_test;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hE1DB));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_COUNT, 32'h00);
    rdc(`OFS_PERIOD, 32'hFF);
    rdc(`OFS_CONTROL, 32'h00);
    apb(1'b0, 12'h018, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `OFS_INT_FLAGS, 32'h2);
    chk(er, 1'b1);
    m = $urandom;
    apb(1'b1, `OFS_PERIOD, m);
    rdc(`OFS_PERIOD, m & 32'hFF);
    $display("registers done");
    for (c = 0; c < 4; c++) begin
      per = $urandom_range(0, 6);
      ps = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_COUNT, 32'h0);
      apb(1'b1, `OFS_PERIOD, per);
      mt.delete();
      apb(1'b1, `OFS_CONTROL, 32'h4 | c);
      wait_n(3, 1'b0);
      chk(mt[2] - mt[1], (per + 1) * 4 * ps * 25);
    end
    $display("prescale done");
    per = 1;
    foreach (ps_list[i]) begin
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_COUNT, 32'h0);
      apb(1'b1, `OFS_PERIOD, per);
      apb(1'b1, `OFS_INT_ENABLE, 32'h2);
      apb(1'b1, `OFS_INT_CLEAR, 32'h2);
      rdc(`OFS_INT_FLAGS, 32'h0);
      mt.delete();
      apb(1'b1, `OFS_CONTROL, (ps_list[i] << 3) | 32'h4);
      wait_n(99, 1'b1);
      chk(mt.size(), ps_list[i] + 1);
      apb(1'b1, `OFS_CONTROL, 32'h0);
      rdc(`OFS_INT_FLAGS, 32'h2);
      apb(1'b1, `OFS_INT_ENABLE, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, `OFS_INT_ENABLE, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
    end
    $display("postscale done");
    m = count_out;
    repeat (40) @(posedge pclk);
    chk(count_out, m);
    apb(1'b1, `OFS_CONTROL, 32'h2);
    rdc(`OFS_COUNT, m);
    m = $urandom;
    apb(1'b1, `OFS_COUNT, m);
    rdc(`OFS_COUNT, m & 32'hFF);
    apb(1'b1, `OFS_CONTROL, 32'h4);
    repeat (10) @(posedge pclk);
    chk(count_out !== m[7:0], 1'b1);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_COUNT, 32'h00);
    rdc(`OFS_PERIOD, 32'hFF);
    $display("control done");
    end_of_test;
  end
endmodule
`default_nettype wire
